// ### dims_port.sv
`timescale 1ns/1ps
`include "dims_map.svh"

module dims_port
  import dims_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [1:0] sda_in,
  input wire logic [1:0] scl_in,
  output logic [1:0] sda_out,
  output logic [1:0] sda_oe,
  output logic [1:0] scl_out,
  output logic [1:0] scl_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  localparam logic [9:0] DIVS [8] = '{`DIMS_DIV0, `DIMS_DIV1, `DIMS_DIV2, `DIMS_DIV3,
    `DIMS_DIV4, `DIMS_DIV5, `DIMS_DIV6, `DIMS_DIV7};

  logic [7:0] ch_rd [`DIMS_NCH];

  ////////////////////////////////////////////////////////////////////////////////
  // Shared read port; open-drain lines only ever pull low
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sfr_rdata <= 8'h00;
      sda_out <= 2'h0;
      scl_out <= 2'h0;
    end
    else
    begin
      sda_out <= 2'h0;
      scl_out <= 2'h0;
      if (sfr_rd)
        sfr_rdata <= ch_rd[sfr_addr[`DIMS_CH_BIT]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One complete controller per channel
  for (genvar i = 0; i < `DIMS_NCH; i++)
  begin : g_ch
    logic [7:0] ctrl, adr, sh, rxb;
    logic scl_p, sda_p, sda_q, scl_q, busy, mst, slv, tx, addr_ph, hold, pend;
    logic bus_event_flag, stop_f, blost, nack, addr_f, sta_q, sto_q;
    logic [3:0] bcnt;
    logic [9:0] tmr;
    dims_mst_t mstate, next_mstate;
    dims_buf_if bf ();
    dims_rx_buf u_buf
    (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .b(bf.fifo)
    );
    //////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire sel = sfr_addr[`DIMS_CH_BIT] == 1'(i);
    wire [1:0] idx = sfr_addr[`DIMS_IDX_MSB:0];
    wire wr_ctl = sfr_wr & sel & (idx == `DIMS_REG_CTRL);
    wire wr_dat = sfr_wr & sel & (idx == `DIMS_REG_DATA);
    wire wr_adr = sfr_wr & sel & (idx == `DIMS_REG_ADR);
    wire rd_st = sfr_rd & sel & (idx == `DIMS_REG_STAT);
    wire rd_dat = sfr_rd & sel & (idx == `DIMS_REG_DATA);
    wire en = ctrl[`DIMS_CTL_EN];
    wire ack_en = ctrl[`DIMS_CTL_AA];
    wire [2:0] cs = {ctrl[`DIMS_CTL_CS2], ctrl[`DIMS_CTL_CS1], ctrl[`DIMS_CTL_CS0]};
    wire [9:0] half = DIVS[cs] >> 1;
    wire tick = tmr >= half - 10'h001;
    //////////////////////////////////////////////////////////////////////////////
    // Bus events
    wire rise = scl_in[i] & ~scl_p;
    wire start_d = scl_in[i] & scl_p & sda_p & ~sda_in[i];
    wire stop_d = scl_in[i] & scl_p & ~sda_p & sda_in[i];
    wire shift_pt = rise & busy & (bcnt < `DIMS_NBITS);
    wire ack_pt = rise & busy & (bcnt == `DIMS_NBITS);
    wire match = sh[`DIMS_ADR_MSB:`DIMS_ADR_LSB] == adr[`DIMS_ADR_MSB:`DIMS_ADR_LSB];
    wire s_hit = addr_ph & ~mst & match & ack_en;
    wire party = mst | slv;
    wire evt = ack_pt & (party | s_hit | blost);
    wire lost = shift_pt & mst & tx & ~sda_q & ~sda_in[i];
    wire d_tx = tx & party & (bcnt < `DIMS_NBITS) & ~sh[`DIMS_MSB];
    wire d_ack = (bcnt == `DIMS_NBITS) & ack_en & (s_hit | (~addr_ph & ~tx & party));
    wire rel = (wr_dat | wr_ctl) & ~pend;
    wire enter_start = (next_mstate == M_START) & (mstate != M_START);
    //////////////////////////////////////////////////////////////////////////////
    // Master phase decode
    wire m_hi = mstate inside {M_START, M_HIGH, M_RS2, M_STOP2, M_STOP3};
    wire m_ovr = mstate inside {M_START, M_RS, M_RS2, M_STOP1, M_STOP2, M_STOP3};
    wire m_sda_low = mstate inside {M_START, M_STOP1, M_STOP2};
    wire m_scl_low = mstate inside {M_LOW, M_RS, M_STOP1};
    //////////////////////////////////////////////////////////////////////////////
    // Read-back
    wire [7:0] stat = {1'b0, stop_f, bus_event_flag, tx & party, busy & ~mst, blost, nack, slv};
    wire [7:0] ctl_rd = {ctrl[`DIMS_CTL_CS2], en, sta_q, sto_q, addr_f, ack_en,
      ctrl[`DIMS_CTL_CS1], ctrl[`DIMS_CTL_CS0]};
    wire [7:0] adr_rd = {adr[`DIMS_ADR_MSB:`DIMS_ADR_LSB], 1'b0};
    wire [7:0] dat_rd = bf.out_valid ? bf.out_data : sh;
    assign ch_rd[i] = (idx == `DIMS_REG_CTRL) ? ctl_rd :
      (idx == `DIMS_REG_STAT) ? stat :
      (idx == `DIMS_REG_DATA) ? dat_rd : adr_rd;
    assign bf.in_valid = pend;
    assign bf.in_data = rxb;
    assign bf.out_ready = rd_dat;
    assign sda_oe[i] = sda_q;
    assign scl_oe[i] = scl_q;
    //////////////////////////////////////////////////////////////////////////////
    // Master clock generator
    always_comb
    begin
      next_mstate = mstate;
      unique case (mstate)
        M_IDLE:
          if (sta_q && !busy)
            next_mstate = M_START;
        M_START:
          if (tick)
            next_mstate = M_LOW;
        M_LOW:
          if (tick && hold && sto_q)
            next_mstate = M_STOP1;
          else if (tick && hold && sta_q)
            next_mstate = M_RS;
          else if (tick && !hold && !pend)
            next_mstate = M_HIGH;
        M_HIGH:
          if (tick)
            next_mstate = M_LOW;
        M_RS:
          if (tick)
            next_mstate = M_RS2;
        M_RS2:
          if (tick)
            next_mstate = M_START;
        M_STOP1:
          if (tick)
            next_mstate = M_STOP2;
        M_STOP2:
          if (tick)
            next_mstate = M_STOP3;
        M_STOP3:
          if (tick)
            next_mstate = M_IDLE;
      endcase
      if (!en || lost)
        next_mstate = M_IDLE;
    end

    // High phase counts from our release; a slave holding the line low restarts it
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        mstate <= M_IDLE;
        tmr <= 10'h000;
      end
      else
      begin
        mstate <= next_mstate;
        if (next_mstate != mstate || (m_hi && !scl_q && !scl_in[i]))
          tmr <= 10'h000;
        else if (!tick)
          tmr <= tmr + 10'h001;
      end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Bus monitor
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        scl_p <= 1'b1;
        sda_p <= 1'b1;
        busy <= 1'b0;
      end
      else
      begin
        scl_p <= scl_in[i];
        sda_p <= sda_in[i];
        busy <= en & (start_d | (busy & ~stop_d));
      end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Role tracking
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        mst <= 1'b0;
        slv <= 1'b0;
      end
      else
      begin
        if (!en || stop_d || lost)
          mst <= 1'b0;
        else if (enter_start)
          mst <= 1'b1;
        if (!en || stop_d || start_d)
          slv <= 1'b0;
        else if (evt && s_hit)
          slv <= 1'b1;
      end
    end

    // Direction follows the read/write bit of the address byte
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
        tx <= 1'b0;
      else if (!en || stop_d || lost)
        tx <= 1'b0;
      else if (start_d)
        tx <= mst;
      else if (ack_pt && s_hit)
        tx <= sh[`DIMS_RW_BIT];
      else if (ack_pt && addr_ph && mst)
        tx <= ~sh[`DIMS_RW_BIT];
      else if (ack_pt && slv && tx && sda_in[i])
        tx <= 1'b0;
    end
    //////////////////////////////////////////////////////////////////////////////
    // Bit counter and shifter
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        bcnt <= 4'h0;
        addr_ph <= 1'b0;
      end
      else if (start_d)
      begin
        bcnt <= 4'h0;
        addr_ph <= 1'b1;
      end
      else if (ack_pt)
      begin
        bcnt <= 4'h0;
        addr_ph <= 1'b0;
      end
      else if (shift_pt)
        bcnt <= bcnt + 4'h1;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        sh <= 8'h00;
        rxb <= 8'h00;
      end
      else
      begin
        if (wr_dat)
          sh <= sfr_wdata;
        else if (shift_pt)
          sh <= {sh[`DIMS_MSB - 1:0], sda_in[i]};
        if (ack_pt)
          rxb <= sh;
      end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Event flags; a hardware set always beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        hold <= 1'b0;
        pend <= 1'b0;
        bus_event_flag <= 1'b0;
        stop_f <= 1'b0;
        blost <= 1'b0;
        nack <= 1'b0;
        addr_f <= 1'b0;
      end
      else
      begin
        hold <= en & ~start_d & ~stop_d & (evt | (hold & ~rel));
        pend <= (ack_pt & ~addr_ph & ~tx & party) | (pend & ~bf.in_ready);
        bus_event_flag <= evt | (stop_d & slv) | (bus_event_flag & ~rd_st);
        stop_f <= stop_d | (stop_f & ~rd_st);
        blost <= lost | (blost & ~rd_st);
        nack <= ack_pt ? sda_in[i] : nack;
        addr_f <= (evt & s_hit) | (addr_f & ~(wr_ctl & ~sfr_wdata[`DIMS_CTL_ADDR]));
      end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        ctrl <= `DIMS_CTL_RST;
        adr <= `DIMS_ADR_RST;
        sta_q <= 1'b0;
        sto_q <= 1'b0;
      end
      else
      begin
        if (wr_ctl)
          ctrl <= sfr_wdata;
        if (wr_adr)
          adr <= sfr_wdata;
        if (wr_ctl)
          sta_q <= sfr_wdata[`DIMS_CTL_STA];
        else if (enter_start || !en)
          sta_q <= 1'b0;
        if (wr_ctl)
          sto_q <= sfr_wdata[`DIMS_CTL_STO];
        else if (stop_d)
          sto_q <= 1'b0;
      end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Line drivers; outside the START, repeated START and STOP phases, data only moves while the clock is low
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
      begin
        sda_q <= 1'b0;
        scl_q <= 1'b0;
      end
      else
      begin
        sda_q <= en & (m_ovr ? m_sda_low : (scl_in[i] ? sda_q : (d_tx | d_ack)));
        scl_q <= en & (m_scl_low | (slv & (hold | pend) & ~scl_in[i]));
      end
    end
    //////////////////////////////////////////////////////////////////////////////
    // Checks
    a_dis_release: assert property (!en |=> !sda_q && !scl_q)
      else $error("line driven while disabled");
    a_bus_event_flag_rdclr: assert property (rd_st && !ack_pt && !stop_d |=> !bus_event_flag)
      else $error("event flag survived status read");
    a_stop_clr: assert property (stop_d && !wr_ctl |=> !sto_q)
      else $error("stop request not cleared by bus stop");
    a_addr_sticky: assert property (addr_f && !wr_ctl |=> addr_f)
      else $error("address flag dropped without software");
    a_ack_low: assert property (en && !m_ovr && !scl_in[i] && d_ack |=> sda_q)
      else $error("acknowledge not driven");
    a_nack_rel: assert property (en && !m_ovr && !scl_in[i] && !ack_en &&
      bcnt == `DIMS_NBITS |=> !sda_q)
      else $error("data held low with acknowledge disabled");
    a_lost_flag: assert property (lost |=> !mst && blost && mstate == M_IDLE)
      else $error("arbitration loss not handled");
    a_start_free: assert property ($rose(mstate == M_START) && $past(mstate) == M_IDLE
      |-> $past(!busy))
      else $error("start made on a busy bus");
    a_stop_gate: assert property ($rose(mstate == M_STOP1) |-> $past(hold && sto_q))
      else $error("stop made without request");
    a_half_low: assert property ($rose(mstate == M_HIGH) |-> $past(tmr) == half - 10'h001)
      else $error("low phase length wrong");
    c_mst_start: cover property (mstate == M_START && tick);
    c_slv_hit: cover property (evt && s_hit);
    c_arb_lost: cover property (lost);
    c_mst_stop: cover property (stop_d && mstate == M_STOP3);
  end
endmodule : dims_port

// ### dims_map.svh
`ifndef DIMS_MAP_SVH
`define DIMS_MAP_SVH
// Functional notes
// - Two independent controllers, each with its own data and clock line.
// - Byte transport, clocking, address match and arbitration all done in hardware.
// - Roles: master transmitter, master receiver, slave transmitter, slave receiver.
// - Control bits: clock select 2,enable,start,stop,address flag,ack enable,select 1,0.
// - Master clock divisor by clock select: 16,24,30,60,120,240,480,960.
// - Enable low releases both data and clock lines.
// - Start request waits for a free bus, then makes a START.
// - Start request during own transfer makes a repeated START.
// - Stop request in master mode makes a STOP.
// - A STOP seen on the bus clears the stop request.
// - Stop request set one event period ahead; STOP follows after that period.
// - Address flag set on own address acknowledged; stays until software clears it.
// - Ack enable set: pull data low in the acknowledge clock.
// - Ack enable clear: release data high in the acknowledge clock.
// - Status byte usable directly as a service routine vector.
// - Shift register moves most significant bit first, shifting toward the top.
// - Reading status clears the event flag.
// - Own address sits in bits 7 to 1; slave answers that address.
`define DIMS_NCH 2
`define DIMS_CH_BIT 2
`define DIMS_IDX_MSB 1
`define DIMS_REG_CTRL 2'h0
`define DIMS_REG_STAT 2'h1
`define DIMS_REG_DATA 2'h2
`define DIMS_REG_ADR 2'h3
`define DIMS_CTL_CS2 7
`define DIMS_CTL_EN 6
`define DIMS_CTL_STA 5
`define DIMS_CTL_STO 4
`define DIMS_CTL_ADDR 3
`define DIMS_CTL_AA 2
`define DIMS_CTL_CS1 1
`define DIMS_CTL_CS0 0
`define DIMS_CTL_RST 8'h00
`define DIMS_ADR_RST 8'h00
`define DIMS_ADR_MSB 7
`define DIMS_ADR_LSB 1
`define DIMS_RW_BIT 0
`define DIMS_MSB 7
`define DIMS_NBITS 4'h8
`define DIMS_DIV0 10'h010
`define DIMS_DIV1 10'h018
`define DIMS_DIV2 10'h01E
`define DIMS_DIV3 10'h03C
`define DIMS_DIV4 10'h078
`define DIMS_DIV5 10'h0F0
`define DIMS_DIV6 10'h1E0
`define DIMS_DIV7 10'h3C0
`define DIMS_BUF_DEPTH 2'h2
`endif

// ### dims_pkg.sv
package dims_pkg;
  typedef logic [7:0] dims_byte_t;
  typedef enum {M_IDLE, M_START, M_LOW, M_HIGH, M_RS, M_RS2, M_STOP1, M_STOP2, M_STOP3}
    dims_mst_t;
endpackage : dims_pkg

// ### dims_buf_if.sv
`timescale 1ns/1ps
interface dims_buf_if;
  logic [7:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [7:0] out_data;
  logic out_valid;
  logic out_ready;
  modport fifo (input in_data, input in_valid, output in_ready,
    output out_data, output out_valid, input out_ready);
  modport user (output in_data, output in_valid, input in_ready,
    input out_data, input out_valid, output out_ready);
endinterface : dims_buf_if

// ### dims_rx_buf.sv
`timescale 1ns/1ps
`include "dims_map.svh"

module dims_rx_buf
  import dims_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  dims_buf_if.fifo b
);
  dims_byte_t mem [`DIMS_BUF_DEPTH];
  logic wp;
  logic rp;
  logic [1:0] cnt;
  wire push = b.in_valid & b.in_ready;
  wire pop = b.out_valid & b.out_ready;

  assign b.in_ready = cnt != `DIMS_BUF_DEPTH;
  assign b.out_valid = cnt != 2'h0;
  assign b.out_data = mem[rp];

  // Data words need no reset; only pointers and count do
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wp] <= b.in_data;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end
    else
    begin
      wp <= wp ^ push;
      rp <= rp ^ pop;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : dims_rx_buf

// ### dims_slv_model.sv
`timescale 1ns/1ps
module dims_slv_model #(
  parameter logic [6:0] OWN_ADDR = 7'h52,
  parameter logic [7:0] TX_BYTE = 8'hC3
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda,
  input wire logic slow,
  output logic sda_pull,
  output logic scl_pull,
  output logic [7:0] got_byte,
  output logic ack_seen,
  output int start_cnt,
  output int stop_cnt,
  output int period
);
  logic pscl;
  logic psda;
  logic sel;
  logic rd;
  logic in_adr;
  logic [3:0] bitc;
  logic [7:0] sh;
  int cyc;
  int last_rise;
  int hold;

  ////////////////////////////////////////////////////////////////////////////
  // Lines sampled on the system clock, as the device itself sees them
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {pscl, psda, sda_pull, scl_pull, ack_seen} <= 5'h18;
      got_byte <= 8'h00;
      {sel, rd, in_adr} = 3'h0;
      {bitc, sh} = 12'h000;
      {start_cnt, stop_cnt, period} = 96'h0;
      {cyc, last_rise, hold} = 96'h0;
    end
    else
    begin
      pscl <= scl;
      psda <= sda;
      cyc = cyc + 1;
      if (hold != 0)
        hold = hold - 1;
      if (scl && pscl && psda && !sda)
      begin
        start_cnt = start_cnt + 1;
        bitc = 4'h0;
        in_adr = 1'b1;
        sel = 1'b0;
        rd = 1'b0;
        sda_pull <= 1'b0;
      end
      else if (scl && pscl && !psda && sda)
      begin
        stop_cnt = stop_cnt + 1;
        sel = 1'b0;
        sda_pull <= 1'b0;
      end
      else if (scl && !pscl)
      begin
        period = cyc - last_rise;
        last_rise = cyc;
        if (bitc < 4'h8)
        begin
          sh = {sh[6:0], sda};
          bitc = bitc + 4'h1;
        end
        else
        begin
          bitc = 4'h0;
          if (rd && !in_adr)
          begin
            ack_seen <= sda;
            if (sda)
              sel = 1'b0;
          end
          in_adr = 1'b0;
        end
      end
      else if (!scl && pscl)
      begin
        if (bitc == 4'h8)
        begin
          if (in_adr)
          begin
            sel = (sh[7:1] == OWN_ADDR);
            rd = sh[0];
          end
          got_byte <= sh;
          sda_pull <= sel && !(rd && !in_adr);
        end
        else if (sel && rd && !in_adr)
          sda_pull <= ~TX_BYTE[7 - bitc];
        else
          sda_pull <= 1'b0;
        // Slow answer: stretch the low phase after each acknowledge
        if (bitc == 4'h0 && sel && slow)
          hold = 20;
      end
      scl_pull <= (hold != 0);
    end
  end
endmodule : dims_slv_model

// ### dims_port_tb.sv
`timescale 1ns/1ps
module dims_port_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] sfr_addr = 3'h0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [1:0] sda_in;
  logic [1:0] scl_in;
  logic [1:0] sda_out;
  logic [1:0] sda_oe;
  logic [1:0] scl_out;
  logic [1:0] scl_oe;
  logic slow = 1'b0;
  logic m_sda_pull;
  logic m_scl_pull;
  logic [7:0] got_byte;
  logic ack_seen;
  int start_cnt;
  int stop_cnt;
  int period;
  int n_fail = 0;
  int cmp_count = 0;

  always #5 ref_clk = ~ref_clk;

  // Open drain with pull-ups: a line is high unless someone pulls it
  assign sda_in = {~sda_oe[1], ~(sda_oe[0] | m_sda_pull)};
  assign scl_in = {~scl_oe[1], ~(scl_oe[0] | m_scl_pull)};

  dims_port u_dut (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sda_in(sda_in),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe));

  dims_slv_model u_slv (.ref_clk(ref_clk), .rstn(rstn), .scl(scl_in[0]), .sda(sda_in[0]),
    .slow(slow), .sda_pull(m_sda_pull), .scl_pull(m_scl_pull), .got_byte(got_byte),
    .ack_seen(ack_seen), .start_cnt(start_cnt), .stop_cnt(stop_cnt), .period(period));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk_int(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp)
    begin
      n_fail++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_int

  task automatic wr(input logic ch, input logic [1:0] idx, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = {ch, idx};
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic ch, input logic [1:0] idx, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = {ch, idx};
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    @(negedge ref_clk);
    d = sfr_rdata;
  endtask : rd

  // Polling clears the flag, so the returned status is the one that showed it
  task automatic wait_evt(output logic [7:0] st);
    int i;
    st = 8'h00;
    for (i = 0; i < 5000 && st[5] !== 1'b1; i++)
      rd(1'b0, 2'h1, st);
    chk8("event flag", 8'h20, st & 8'h20);
  endtask : wait_evt

  task automatic wait_stop(input int n);
    int i;
    for (i = 0; i < 20000 && stop_cnt != n; i++)
      @(negedge ref_clk);
    chk_int("stop count", n, stop_cnt);
  endtask : wait_stop

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] d;
    int k;
    for (k = 0; k < 8; k++)
    begin
      rd(k[2], k[1:0], d);
      chk8("reset value", 8'h00, d);
    end
    chk8("released lines", 8'h00, {sda_out, scl_out, sda_oe, scl_oe});
  endtask : t_reset

  task automatic t_regs;
    logic [7:0] d;
    wr(1'b1, 2'h3, 8'hA5);
    rd(1'b1, 2'h3, d);
    chk8("own address", 8'hA4, d);
    wr(1'b1, 2'h0, 8'h87);
    rd(1'b1, 2'h0, d);
    chk8("control bits", 8'h87, d);
    chk8("disabled lines", 8'h00, {4'h0, sda_oe, scl_oe});
    wr(1'b1, 2'h0, 8'h00);
  endtask : t_regs

  // Write then read on channel 0 against a slave that stretches the clock
  task automatic t_master;
    logic [7:0] st;
    logic [7:0] d;
    slow = 1'b1;
    wr(1'b0, 2'h2, 8'hA4);
    wr(1'b0, 2'h0, 8'h60);
    wait_evt(st);
    chk8("address status", 8'h30, st & 8'h33);
    chk8("address on wire", 8'hA4, got_byte);
    rd(1'b0, 2'h1, st);
    chk8("flag after read", 8'h00, st & 8'h20);
    wr(1'b0, 2'h2, 8'h3C);
    wait_evt(st);
    chk8("data on wire", 8'h3C, got_byte);
    wr(1'b0, 2'h0, 8'h50);
    wait_evt(st);
    wait_stop(1);
    rd(1'b0, 2'h0, d);
    chk8("stop request cleared", 8'h40, d);
    wr(1'b0, 2'h2, 8'hA5);
    wr(1'b0, 2'h0, 8'h64);
    wait_evt(st);
    chk8("receiver status", 8'h20, st & 8'h33);
    wr(1'b0, 2'h0, 8'h44);
    wait_evt(st);
    rd(1'b0, 2'h2, d);
    chk8("received byte", 8'hC3, d);
    chk8("ack driven", 8'h00, {7'h00, ack_seen});
    wr(1'b0, 2'h0, 8'h40);
    wait_evt(st);
    rd(1'b0, 2'h2, d);
    chk8("second byte", 8'hC3, d);
    chk8("ack withheld", 8'h01, {7'h00, ack_seen});
    wr(1'b0, 2'h0, 8'h50);
    wait_evt(st);
    rd(1'b0, 2'h2, d);
    chk8("released bus byte", 8'hFF, d);
    wait_stop(2);
  endtask : t_master

  // Every clock select code, addressed to nobody so each byte ends in a refusal
  task automatic t_div;
    int div[8] = '{16, 24, 30, 60, 120, 240, 480, 960};
    logic [7:0] st;
    int k;
    slow = 1'b0;
    for (k = 0; k < 8; k++)
    begin
      wr(1'b0, 2'h2, 8'h20);
      wr(1'b0, 2'h0, {k[2], 5'b11000, k[1:0]});
      wait_evt(st);
      chk_int("scl period", div[k], period);
      chk8("nack seen", 8'h02, st & 8'h02);
      wr(1'b0, 2'h0, {k[2], 5'b10100, k[1:0]});
      wait_evt(st);
      wait_stop(3 + k);
    end
    wr(1'b0, 2'h0, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk8("lines after disable", 8'h00, {sda_out, scl_out, sda_oe, scl_oe});
  endtask : t_div

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Longest run is the slowest divisor pass, well under this span
  initial
  begin
    #1ms;
    n_fail++;
    $display("BAD watchdog expected done seen timeout");
    end_sim;
  end

  initial
  begin
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset;
    t_regs;
    t_master;
    t_div;
    end_sim;
  end
endmodule : dims_port_tb
